// ==== hw/dfhf_regs.svh ====
// Register offsets, field ranges, encodings and sizes of the DMA flow and
// handshake front end. Definitions only; included by bare name.
`ifndef DFHF_REGS_SVH
`define DFHF_REGS_SVH

// Sizes
`define DFHF_N_CH 12
`define DFHF_N_LINE 12
`define DFHF_N_SRC 16
`define DFHF_SEL_PER_REG 8

// Address areas, byte addresses on the 12-bit register port
`define DFHF_CH_MASK 12'he00
`define DFHF_CH_BASE 12'h000
`define DFHF_GLOB_MASK 12'hfe0
`define DFHF_GLOB_BASE 12'h400
`define DFHF_A_CH 8:5
`define DFHF_A_REG 4:2

// Per-channel word index inside a 32-byte channel window
`define DFHF_R_CTL_LO 3'h0
`define DFHF_R_CTL_HI 3'h1
`define DFHF_R_CFG_LO 3'h2
`define DFHF_R_CFG_HI 3'h3
`define DFHF_R_INFO 3'h4

// Global word index inside the global window
`define DFHF_G_SRSEL0 3'h0
`define DFHF_G_SRSEL1 3'h1
`define DFHF_G_LNEN 3'h2
`define DFHF_G_SWSRC 3'h3
`define DFHF_G_SWDST 3'h4
`define DFHF_G_PEND 3'h5

// Writable bits of each channel register; the rest read as zero
`define DFHF_MASK_CTL_LO 32'h0000_0777
`define DFHF_MASK_CTL_HI 32'h0000_0fff
`define DFHF_MASK_CFG_LO 32'h0000_000f
`define DFHF_MASK_CFG_HI 32'h0000_00ff

// Field ranges
`define DFHF_F_FLOW 2:0
`define DFHF_F_SRC_WIDTH 6:4
`define DFHF_F_DST_WIDTH 10:8
`define DFHF_F_BLOCK 11:0
`define DFHF_F_HS_SRC 0
`define DFHF_F_HS_DST 1
`define DFHF_F_POL_SRC 2
`define DFHF_F_POL_DST 3
`define DFHF_F_SRC_LINE 3:0
`define DFHF_F_DST_LINE 7:4
`define DFHF_F_SW_BITS 11:0
`define DFHF_F_SW_WE 27:16
`define DFHF_F_FIFO 7:0
`define DFHF_F_BURST 11:8
`define DFHF_F_ST_SRC 16
`define DFHF_F_ST_DST 17

// Transfer flow codes
`define DFHF_FL_M2M_DMA 3'h0
`define DFHF_FL_M2P_DMA 3'h1
`define DFHF_FL_P2M_DMA 3'h2
`define DFHF_FL_P2P_DMA 3'h3
`define DFHF_FL_P2M_PER 3'h4
`define DFHF_FL_P2P_SRC 3'h5
`define DFHF_FL_M2P_PER 3'h6
`define DFHF_FL_P2P_DST 3'h7

// Item widths
`define DFHF_W_8 3'h0
`define DFHF_W_16 3'h1
`define DFHF_W_32 3'h2

// Channel buffer and burst sizes
`define DFHF_BIG_CHANS 2
`define DFHF_FIFO_BIG 8'h20
`define DFHF_FIFO_SMALL 8'h08
`define DFHF_BURST_BIG 4'h8
`define DFHF_BURST_SMALL 4'h1

`endif

// ==== hw/dfhf_pkg.sv ====
// Types shared by both ends of the DMA flow and handshake front end.
// Assumes dfhf_regs.svh for all numbers.
`include "dfhf_regs.svh"
package dfhf_pkg;
  typedef logic [2:0] dfhf_flow_t;
  typedef logic [`DFHF_N_SRC-1:0] dfhf_src_vec_t;
  // Roles that one transfer flow code gives to each side
  typedef struct packed {
    logic source_line_number;
    logic dst_per;
    logic src_fc;
    logic dst_fc;
  } dfhf_role_t;
endpackage : dfhf_pkg

// ==== hw/dfhf_hs_if.sv ====
// Service request wiring between peripherals and the DMA front end.
// Assumes both ends share core_clk_i; no clocking inside.
`timescale 1ns/10ps
`default_nettype none
interface dfhf_hs_if;
  dfhf_pkg::dfhf_src_vec_t req;  // Service request per source, high
  dfhf_pkg::dfhf_src_vec_t last; // Last item, peripheral flow control
  dfhf_pkg::dfhf_src_vec_t ack;  // Request served, one-cycle pulse
  modport dev (input req, input last, output ack);
  modport periph (output req, output last, input ack);
endinterface : dfhf_hs_if
`default_nettype wire

// ==== hw/dfhf_periph.sv ====
// Peripheral end: holds a service request per source until served.
// Assumes the device end on the same core_clk_i across dfhf_hs_if.
`timescale 1ns/10ps
`default_nettype none
`include "dfhf_regs.svh"
module dfhf_periph (
  input wire logic core_clk_i, // System clock, 20 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  dfhf_hs_if.periph hs, // Request wires to the device
  input wire logic [`DFHF_N_SRC-1:0] raise_i, // Ready to move data
  input wire logic [`DFHF_N_SRC-1:0] last_i, // Final item of block
  output logic [`DFHF_N_SRC-1:0] pending_o, // Request still open
  output logic [`DFHF_N_SRC-1:0] served_o // Served, one pulse
);
  logic [`DFHF_N_SRC-1:0] req_ff, nxt_req;
  logic [`DFHF_N_SRC-1:0] last_ff, nxt_last;
  logic [`DFHF_N_SRC-1:0] served_ff, nxt_served;

  // Readiness stands until the device acks; a new raise beats the ack
  always_comb begin
    nxt_req = raise_i | (req_ff & ~hs.ack);
    nxt_last = (raise_i & last_i) | (last_ff & ~hs.ack & ~raise_i);
    nxt_served = hs.ack & ~raise_i;
  end

  // Registers only
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      req_ff <= '0;
      last_ff <= '0;
      served_ff <= '0;
    end else begin
      req_ff <= nxt_req;
      last_ff <= nxt_last;
      served_ff <= nxt_served;
    end
  end

  // Wires out come straight from flops
  assign hs.req = req_ff;
  assign hs.last = last_ff;
  assign pending_o = req_ff;
  assign served_o = served_ff;
endmodule : dfhf_periph
`default_nettype wire

// ==== hw/dfhf_dev.sv ====
// Device end: request router, per-channel flow and handshake selection,
// software requests and channel settings, behind a simple register port.
// Assumes the engine core pulses src_done_i/dst_done_i when it takes a
// request, and peripherals on dfhf_hs_if on this same clock.
//
// Overview of operation
// - Flow field picks DMA, source or destination controller
// - Software picks DMA control when size known
// - Peripheral signals readiness; last follows flow controller
// - Handshake select zero gives hardware handshake per side
// - Requests active high; polarity bit inverts per side
// - Twelve router lines, each selects one source
// - Line enable gates; writing it drops pending
// - Channel picks router line per side
// - Handshake select one gives software requests
// - Source request bit written only with enable, cleared when taken
// - Destination request bit written only with enable, cleared when taken
// - Independent source, destination widths 8/16/32
// - Block item count per channel
// - Hardware or software request per side setting
// - Channels 0,1 32-byte buffer, burst 8
`timescale 1ns/10ps
`default_nettype none
`include "dfhf_regs.svh"
module dfhf_dev (
  input wire logic core_clk_i, // System clock, 20 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  dfhf_hs_if.dev hs, // Peripheral request wires
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [11:0] reg_addr_i, // Byte address
  input wire logic [31:0] reg_wdata_i, // Write data
  output logic [31:0] reg_rdata_o, // Read data
  output logic reg_rvalid_o, // Read data valid pulse
  input wire logic [`DFHF_N_CH-1:0] src_done_i, // Source request taken
  input wire logic [`DFHF_N_CH-1:0] dst_done_i, // Dest request taken
  output logic [`DFHF_N_CH-1:0] src_req_o, // Source side ready
  output logic [`DFHF_N_CH-1:0] dst_req_o, // Destination side ready
  output logic [`DFHF_N_CH-1:0] src_last_o, // Source ends block
  output logic [`DFHF_N_CH-1:0] dst_last_o // Destination ends block
);
  localparam int NC = `DFHF_N_CH;
  localparam int NL = `DFHF_N_LINE;

  // Roles of each side for a flow code
  function automatic dfhf_pkg::dfhf_role_t flow_role(
      input dfhf_pkg::dfhf_flow_t f);
    dfhf_pkg::dfhf_role_t r;
    r.src_fc = (f == `DFHF_FL_P2M_PER) || (f == `DFHF_FL_P2P_SRC);
    r.dst_fc = (f == `DFHF_FL_M2P_PER) || (f == `DFHF_FL_P2P_DST);
    r.source_line_number = (f == `DFHF_FL_P2M_DMA) || (f == `DFHF_FL_P2P_DMA) ||
                (f == `DFHF_FL_P2P_DST) || r.src_fc;
    r.dst_per = (f == `DFHF_FL_M2P_DMA) || (f == `DFHF_FL_P2P_DMA) ||
                (f == `DFHF_FL_P2P_SRC) || r.dst_fc;
    return r;
  endfunction : flow_role

  // Buffer and burst figures of one channel
  function automatic logic [31:0] chan_info(input int c);
    logic [31:0] v;
    v = '0;
    if (c < `DFHF_BIG_CHANS) begin
      v[`DFHF_F_FIFO] = `DFHF_FIFO_BIG;
      v[`DFHF_F_BURST] = `DFHF_BURST_BIG;
    end else begin
      v[`DFHF_F_FIFO] = `DFHF_FIFO_SMALL;
      v[`DFHF_F_BURST] = `DFHF_BURST_SMALL;
    end
    return v;
  endfunction : chan_info

  // Request and last sampled through three flops
  logic [2*`DFHF_N_SRC-1:0] s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;
  dfhf_pkg::dfhf_src_vec_t lvl_src, lvl_last;

  // Channel registers
  logic [31:0] ctl_lo_ff [NC];
  logic [31:0] ctl_hi_ff [NC];
  logic [31:0] cfg_lo_ff [NC];
  logic [31:0] cfg_hi_ff [NC];
  logic [31:0] nxt_ctl_lo [NC];
  logic [31:0] nxt_ctl_hi [NC];
  logic [31:0] nxt_cfg_lo [NC];
  logic [31:0] nxt_cfg_hi [NC];

  // Router and software request state
  logic [3:0] sel_ff [NL];
  logic [3:0] nxt_sel [NL];
  logic [NL-1:0] en_ff, nxt_en, pend_ff, nxt_pend, lvl_ff, nxt_lvl;
  logic [NC-1:0] sw_src_ff, nxt_sw_src, sw_dst_ff, nxt_sw_dst;
  logic [NC-1:0] sreq_ff, nxt_sreq, dreq_ff, nxt_dreq;
  logic [NC-1:0] slast_ff, nxt_slast, dlast_ff, nxt_dlast;
  dfhf_pkg::dfhf_src_vec_t ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic rvalid_ff;

  // A change counts once the second and third stages agree
  always_comb begin
    nxt_filt = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
    lvl_src = filt_ff[`DFHF_N_SRC-1:0];
    lvl_last = filt_ff[2*`DFHF_N_SRC-1:`DFHF_N_SRC];
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      filt_ff <= '0;
    end else begin
      s1_ff <= {hs.last, hs.req};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Register writes, router capture, channel requests and read data
  always_comb begin
    logic ch_hit;
    logic gl_hit;
    logic [3:0] wch;
    logic [2:0] wreg;
    logic [NL-1:0] pclr;
    logic [NL-1:0] rise;
    logic [NL-1:0] line_lvl;
    dfhf_pkg::dfhf_role_t role;
    logic [3:0] sl;
    logic [3:0] dl;
    logic hw_s;
    logic hw_d;
    logic [NC-1:0] sw_we;
    logic [NC-1:0] sw_bits;
    ch_hit = ((reg_addr_i & `DFHF_CH_MASK) == `DFHF_CH_BASE) &&
             (int'(reg_addr_i[`DFHF_A_CH]) < NC);
    gl_hit = (reg_addr_i & `DFHF_GLOB_MASK) == `DFHF_GLOB_BASE;
    wch = reg_addr_i[`DFHF_A_CH];
    wreg = reg_addr_i[`DFHF_A_REG];
    pclr = '0;
    role = '0;
    sl = '0;
    dl = '0;
    hw_s = 1'b0;
    hw_d = 1'b0;
    line_lvl = '0;
    rise = '0;
    // Request bits and their write enables, one per channel
    sw_we = reg_wdata_i[`DFHF_F_SW_WE];
    sw_bits = reg_wdata_i[`DFHF_F_SW_BITS];
    nxt_ctl_lo = ctl_lo_ff;
    nxt_ctl_hi = ctl_hi_ff;
    nxt_cfg_lo = cfg_lo_ff;
    nxt_cfg_hi = cfg_hi_ff;
    nxt_sel = sel_ff;
    nxt_en = en_ff;
    nxt_sw_src = sw_src_ff;
    nxt_sw_dst = sw_dst_ff;
    nxt_ack = '0;
    nxt_rdata = rdata_ff;
    // Each line follows its selected source, gated by its enable
    for (int l = 0; l < NL; l++) begin
      line_lvl[l] = lvl_src[sel_ff[l]];
      rise[l] = line_lvl[l] & ~lvl_ff[l] & en_ff[l];
    end
    nxt_lvl = line_lvl;
    // Writes; unmapped addresses are ignored
    if (reg_wr_i && ch_hit) begin
      unique case (wreg)
        `DFHF_R_CTL_LO: nxt_ctl_lo[wch] = reg_wdata_i & `DFHF_MASK_CTL_LO;
        `DFHF_R_CTL_HI: nxt_ctl_hi[wch] = reg_wdata_i & `DFHF_MASK_CTL_HI;
        `DFHF_R_CFG_LO: nxt_cfg_lo[wch] = reg_wdata_i & `DFHF_MASK_CFG_LO;
        `DFHF_R_CFG_HI: nxt_cfg_hi[wch] = reg_wdata_i & `DFHF_MASK_CFG_HI;
        default: ;
      endcase
    end
    if (reg_wr_i && gl_hit) begin
      unique case (wreg)
        `DFHF_G_SRSEL0: begin
          for (int l = 0; l < `DFHF_SEL_PER_REG; l++) begin
            nxt_sel[l] = reg_wdata_i[4*l +: 4];
          end
        end
        `DFHF_G_SRSEL1: begin
          for (int l = `DFHF_SEL_PER_REG; l < NL; l++) begin
            nxt_sel[l] = reg_wdata_i[4*(l-`DFHF_SEL_PER_REG) +: 4];
          end
        end
        `DFHF_G_LNEN: begin
          nxt_en = reg_wdata_i[NL-1:0];
          pclr = '1; // Old captures are dropped
        end
        default: ;
      endcase
    end
    // Per channel: pick request source per side
    for (int c = 0; c < NC; c++) begin
      role = flow_role(ctl_lo_ff[c][`DFHF_F_FLOW]);
      sl = cfg_hi_ff[c][`DFHF_F_SRC_LINE];
      dl = cfg_hi_ff[c][`DFHF_F_DST_LINE];
      // Polarity set: the low level of the enabled line is accepted
      hw_s = 1'b0;
      hw_d = 1'b0;
      if (int'(sl) < NL) begin
        hw_s = cfg_lo_ff[c][`DFHF_F_POL_SRC] ? en_ff[sl] & ~line_lvl[sl]
                                              : pend_ff[sl];
      end
      if (int'(dl) < NL) begin
        hw_d = cfg_lo_ff[c][`DFHF_F_POL_DST] ? en_ff[dl] & ~line_lvl[dl]
                                              : pend_ff[dl];
      end
      // Memory sides need no handshake and stand ready
      nxt_sreq[c] = ~role.source_line_number | (cfg_lo_ff[c][`DFHF_F_HS_SRC] ?
                    sw_src_ff[c] : hw_s);
      nxt_dreq[c] = ~role.dst_per | (cfg_lo_ff[c][`DFHF_F_HS_DST] ?
                    sw_dst_ff[c] : hw_d);
      nxt_sreq[c] = nxt_sreq[c] & ~src_done_i[c];
      nxt_dreq[c] = nxt_dreq[c] & ~dst_done_i[c];
      // Last only from a peripheral that is flow controller
      nxt_slast[c] = role.src_fc && int'(sl) < NL &&
                     lvl_last[sel_ff[sl]];
      nxt_dlast[c] = role.dst_fc && int'(dl) < NL &&
                     lvl_last[sel_ff[dl]];
      // A taken hardware request frees its line and acks its source
      if (src_done_i[c] && role.source_line_number && !cfg_lo_ff[c][`DFHF_F_HS_SRC] &&
          int'(sl) < NL) begin
        pclr[sl] = 1'b1;
        nxt_ack[sel_ff[sl]] = 1'b1;
      end
      if (dst_done_i[c] && role.dst_per && !cfg_lo_ff[c][`DFHF_F_HS_DST] &&
          int'(dl) < NL) begin
        pclr[dl] = 1'b1;
        nxt_ack[sel_ff[dl]] = 1'b1;
      end
      // Software bits: a taken request clears first, then an enabled write wins
      if (src_done_i[c]) nxt_sw_src[c] = 1'b0;
      if (dst_done_i[c]) nxt_sw_dst[c] = 1'b0;
      if (reg_wr_i && gl_hit && wreg == `DFHF_G_SWSRC && sw_we[c]) begin
        nxt_sw_src[c] = sw_bits[c];
      end
      if (reg_wr_i && gl_hit && wreg == `DFHF_G_SWDST && sw_we[c]) begin
        nxt_sw_dst[c] = sw_bits[c];
      end
    end
    // New capture wins over a clear in the same cycle
    nxt_pend = rise | (pend_ff & ~pclr);
    // Read data, zero for unmapped addresses
    if (reg_rd_i) begin
      nxt_rdata = '0;
      if (ch_hit) begin
        unique case (wreg)
          `DFHF_R_CTL_LO: nxt_rdata = ctl_lo_ff[wch];
          `DFHF_R_CTL_HI: nxt_rdata = ctl_hi_ff[wch];
          `DFHF_R_CFG_LO: nxt_rdata = cfg_lo_ff[wch];
          `DFHF_R_CFG_HI: nxt_rdata = cfg_hi_ff[wch];
          `DFHF_R_INFO: begin
            nxt_rdata = chan_info(int'(wch));
            nxt_rdata[`DFHF_F_ST_SRC] = sreq_ff[wch];
            nxt_rdata[`DFHF_F_ST_DST] = dreq_ff[wch];
          end
          default: ;
        endcase
      end else if (gl_hit) begin
        unique case (wreg)
          `DFHF_G_SRSEL0: begin
            for (int l = 0; l < `DFHF_SEL_PER_REG; l++) begin
              nxt_rdata[4*l +: 4] = sel_ff[l];
            end
          end
          `DFHF_G_SRSEL1: begin
            for (int l = `DFHF_SEL_PER_REG; l < NL; l++) begin
              nxt_rdata[4*(l-`DFHF_SEL_PER_REG) +: 4] = sel_ff[l];
            end
          end
          `DFHF_G_LNEN: nxt_rdata[NL-1:0] = en_ff;
          `DFHF_G_SWSRC: nxt_rdata[NC-1:0] = sw_src_ff;
          `DFHF_G_SWDST: nxt_rdata[NC-1:0] = sw_dst_ff;
          `DFHF_G_PEND: nxt_rdata[NL-1:0] = pend_ff;
          default: ;
        endcase
      end
    end
  end

  // Registers only; widths and block count sit in the channel words
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ctl_lo_ff <= '{default: '0};
      ctl_hi_ff <= '{default: '0};
      cfg_lo_ff <= '{default: '0};
      cfg_hi_ff <= '{default: '0};
      sel_ff <= '{default: '0};
      en_ff <= '0;
      pend_ff <= '0;
      lvl_ff <= '0;
      sw_src_ff <= '0;
      sw_dst_ff <= '0;
      sreq_ff <= '0;
      dreq_ff <= '0;
      slast_ff <= '0;
      dlast_ff <= '0;
      ack_ff <= '0;
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      ctl_lo_ff <= nxt_ctl_lo;
      ctl_hi_ff <= nxt_ctl_hi;
      cfg_lo_ff <= nxt_cfg_lo;
      cfg_hi_ff <= nxt_cfg_hi;
      sel_ff <= nxt_sel;
      en_ff <= nxt_en;
      pend_ff <= nxt_pend;
      lvl_ff <= nxt_lvl;
      sw_src_ff <= nxt_sw_src;
      sw_dst_ff <= nxt_sw_dst;
      sreq_ff <= nxt_sreq;
      dreq_ff <= nxt_dreq;
      slast_ff <= nxt_slast;
      dlast_ff <= nxt_dlast;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= reg_rd_i;
    end
  end

  // Outputs straight from flops
  assign hs.ack = ack_ff;
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign src_req_o = sreq_ff;
  assign dst_req_o = dreq_ff;
  assign src_last_o = slast_ff;
  assign dst_last_o = dlast_ff;
endmodule : dfhf_dev
`default_nettype wire

// ==== test/dfhf_chk.sv ====
// Checker on the request wires between peripheral end and device end.
// Assumes it sits beside dfhf_hs_if in the testbench, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module dfhf_chk (
  input wire logic core_clk_i, // System clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire dfhf_pkg::dfhf_src_vec_t req, // Service requests
  input wire dfhf_pkg::dfhf_src_vec_t last, // Last item flags
  input wire dfhf_pkg::dfhf_src_vec_t ack // Served pulses
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // Both ends leave the wires quiet on the first edge after reset
  chk_reset_quiet: assert property (
    $rose(resetn_i) |-> (req == '0) && (ack == '0) && (last == '0))
    else $error("wires active after reset");

  // Per source: the request and serve handshake on the wire
  for (genvar s = 0; s < 16; s++) begin : g_src
    sequence s_served;
      ack[s] ##1 (!ack[s] && !req[s]);
    endsequence
    sequence s_quiet;
      !ack[s] [*6];
    endsequence
    chk_ack_pulse: assert property (
      ack[s] |=> !ack[s]) else $error("ack longer than one cycle");
    chk_ack_needs_req: assert property (
      ack[s] |-> req[s]) else $error("ack without open request");
    chk_served_drop: assert property (
      ack[s] |-> s_served) else $error("request kept after ack");
    // The three-flop filter makes an early ack impossible
    chk_ack_latency: assert property (
      $rose(req[s]) |-> s_quiet) else $error("ack too soon after req");
    chk_req_aged: assert property (
      ack[s] |-> $past(req[s], 6)) else $error("ack on young request");
    chk_req_hold: assert property (
      req[s] && !ack[s] |=> req[s]) else $error("request dropped unserved");
    chk_last_with_req: assert property (
      $rose(last[s]) |-> $rose(req[s])) else $error("last without request");
  end
endmodule : dfhf_chk
`default_nettype wire

// ==== test/tb_dma_flow_handshake_frontend.sv ====
// Self-checking bench: device end and peripheral end joined by dfhf_hs_if.
// Assumes the register map and codes of dfhf_regs.svh.
`timescale 1ns/10ps
`default_nettype none
`include "dfhf_regs.svh"
module tb_dma_flow_handshake_frontend;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [11:0] src_done = 12'h000;
  logic [11:0] dst_done = 12'h000;
  logic [11:0] src_req, dst_req, src_last, dst_last;
  logic [15:0] raise = 16'h0000;
  logic [15:0] last_in = 16'h0000;
  logic [15:0] pending, served;
  int error_cnt = 0;
  int n_tests = 0;
  int k;

  dfhf_hs_if dfhf_hs_if_i ();
  dfhf_dev dfhf_dev_i (.core_clk_i(core_clk), .resetn_i(resetn),
    .hs(dfhf_hs_if_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .src_done_i(src_done), .dst_done_i(dst_done),
    .src_req_o(src_req), .dst_req_o(dst_req), .src_last_o(src_last),
    .dst_last_o(dst_last));
  dfhf_periph dfhf_periph_i (.core_clk_i(core_clk), .resetn_i(resetn),
    .hs(dfhf_hs_if_i), .raise_i(raise), .last_i(last_in),
    .pending_o(pending), .served_o(served));
  dfhf_chk dfhf_chk_i (.core_clk_i(core_clk), .resetn_i(resetn),
    .req(dfhf_hs_if_i.req), .last(dfhf_hs_if_i.last),
    .ack(dfhf_hs_if_i.ack));

  // 20 MHz clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [11:0] ca(input int c, input logic [2:0] r);
    return 12'(c * 32) + {7'h00, r, 2'b00};
  endfunction : ca

  function automatic logic [11:0] ga(input logic [2:0] r);
    return `DFHF_GLOB_BASE + {7'h00, r, 2'b00};
  endfunction : ga

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is taken in the cycle the valid pulse shows
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string what);
    int i;
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    for (i = 0; i < 3; i++) begin
      #1;
      if (reg_rvalid === 1'b1) break;
      @(posedge core_clk);
    end
    chk(what, exp, reg_rdata);
  endtask : rd

  task automatic raise_src(input int s, input logic lst);
    @(posedge core_clk);
    raise[s] <= 1'b1;
    last_in[s] <= lst;
    @(posedge core_clk);
    raise <= 16'h0000;
    last_in <= 16'h0000;
  endtask : raise_src

  // Engine takes a request: done pulses for one cycle
  task automatic done(input int ch, input bit dst);
    @(posedge core_clk);
    if (dst) dst_done[ch] <= 1'b1;
    else src_done[ch] <= 1'b1;
    @(posedge core_clk);
    src_done <= 12'h000;
    dst_done <= 12'h000;
    #1;
  endtask : done

  task automatic wait_src(input int ch);
    int i;
    for (i = 0; i < 30; i++) begin
      cyc(1);
      if (src_req[ch] === 1'b1) break;
    end
  endtask : wait_src

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short long after the tests should be over
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    $display("watchdog expired");
    end_sim;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    // Flow code 0 after reset: both memory sides stand ready
    rd(ca(0, `DFHF_R_INFO), 32'h0003_0820, "info ch0");
    rd(ca(5, `DFHF_R_INFO), 32'h0003_0108, "info ch5");
    rd(ca(1, `DFHF_R_CFG_LO), 32'h0, "cfg reset");
    wr(12'h600, 32'hffff_ffff);
    rd(12'h600, 32'h0, "unmapped");
    $display("test reset_map done");
    // Every flow code, with all three widths on each side
    for (k = 0; k < 8; k++) begin
      wr(ca(k, `DFHF_R_CTL_LO), 32'(((k + 1) % 3) << 8 | (k % 3) << 4 | k));
      rd(ca(k, `DFHF_R_CTL_LO), 32'(((k + 1) % 3) << 8 | (k % 3) << 4 | k),
         "ctl low");
    end
    wr(ca(8, `DFHF_R_CTL_LO), 32'hffff_ffff);
    rd(ca(8, `DFHF_R_CTL_LO), 32'h0000_0777, "ctl mask");
    wr(ca(3, `DFHF_R_CTL_HI), 32'hffff_ffff);
    rd(ca(3, `DFHF_R_CTL_HI), 32'h0000_0fff, "block max");
    wr(ca(11, `DFHF_R_CTL_HI), 32'h0000_0abc);
    rd(ca(11, `DFHF_R_CTL_HI), 32'h0000_0abc, "block cnt");
    $display("test fields done");
    // Hardware request: source 5 on line 3 to channels 2 and 4, and to the destination side of channel 8
    wr(ca(2, `DFHF_R_CTL_LO), 32'h2);
    wr(ca(4, `DFHF_R_CTL_LO), 32'h4);
    wr(ca(2, `DFHF_R_CFG_HI), 32'h3);
    wr(ca(4, `DFHF_R_CFG_HI), 32'h3);
    wr(ca(8, `DFHF_R_CFG_HI), 32'h30);
    wr(ga(`DFHF_G_SRSEL0), 32'h0000_5000);
    wr(ga(`DFHF_G_LNEN), 32'h0000_0008);
    raise_src(5, 1'b1);
    wait_src(2);
    chk("src req ch2", 32'h1, 32'(src_req[2]));
    chk("dst req ch2", 32'h1, 32'(dst_req[2]));
    chk("src last", 32'h10, 32'(src_last));
    chk("dst last", 32'h100, 32'(dst_last));
    rd(ca(2, `DFHF_R_INFO), 32'h0003_0108, "info ch2");
    done(2, 1'b0);
    chk("src req taken", 32'h0, 32'(src_req[2]));
    cyc(1);
    chk("served src5", 32'h20, 32'(served));
    cyc(2);
    chk("pending src5", 32'h0, 32'(pending[5]));
    $display("test hw_request done");
    // Disabled line, then pending dropped by a line enable write
    wr(ca(6, `DFHF_R_CTL_LO), 32'h2);
    wr(ca(6, `DFHF_R_CFG_HI), 32'h4);
    wr(ga(`DFHF_G_SRSEL0), 32'h0006_5000);
    raise_src(6, 1'b0);
    cyc(10);
    chk("line off", 32'h0, 32'(src_req[6]));
    wr(ga(`DFHF_G_SRSEL0), 32'h0007_5000);
    wr(ga(`DFHF_G_LNEN), 32'h0000_0018);
    raise_src(7, 1'b0);
    wait_src(6);
    chk("line on", 32'h1, 32'(src_req[6]));
    wr(ga(`DFHF_G_LNEN), 32'h0000_0018);
    cyc(2);
    chk("pending drop", 32'h0, 32'(src_req[6]));
    $display("test line_enable done");
    // Inverted polarity: a low line counts as a request
    wr(ca(7, `DFHF_R_CTL_LO), 32'h2);
    wr(ca(7, `DFHF_R_CFG_LO), 32'h4);
    wr(ca(7, `DFHF_R_CFG_HI), 32'h5);
    wr(ga(`DFHF_G_SRSEL0), 32'h0087_5000);
    wr(ga(`DFHF_G_LNEN), 32'h0000_0038);
    cyc(8);
    chk("pol low", 32'h1, 32'(src_req[7]));
    raise_src(8, 1'b0);
    cyc(8);
    chk("pol high", 32'h0, 32'(src_req[7]));
    $display("test polarity done");
    // Software handshake ignores the line and needs the write enable
    wr(ca(9, `DFHF_R_CTL_LO), 32'h3);
    wr(ca(9, `DFHF_R_CFG_LO), 32'h3);
    wr(ca(9, `DFHF_R_CFG_HI), 32'h33);
    raise_src(5, 1'b0);
    cyc(10);
    chk("sw src idle", 32'h0, 32'(src_req[9]));
    chk("sw dst idle", 32'h0, 32'(dst_req[9]));
    wr(ga(`DFHF_G_SWSRC), 32'h0000_0200);
    rd(ga(`DFHF_G_SWSRC), 32'h0, "sw no we");
    chk("sw no we req", 32'h0, 32'(src_req[9]));
    wr(ga(`DFHF_G_SWSRC), 32'h0200_0200);
    rd(ga(`DFHF_G_SWSRC), 32'h0000_0200, "sw src bit");
    chk("sw src req", 32'h1, 32'(src_req[9]));
    done(9, 1'b0);
    chk("sw src taken", 32'h0, 32'(src_req[9]));
    wr(ga(`DFHF_G_SWDST), 32'h0200_0200);
    cyc(2);
    chk("sw dst req", 32'h1, 32'(dst_req[9]));
    done(9, 1'b1);
    chk("sw dst taken", 32'h0, 32'(dst_req[9]));
    $display("test software done");
    end_sim;
  end
endmodule : tb_dma_flow_handshake_frontend
`default_nettype wire
